// ---- reset_pkg.sv ----
// Shared constants for the device reset controller
package reset_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_IFCFG = 8'h00;   // Interface configuration
    localparam logic [7:0] OFS_STATUS = 8'h04;  // Reset-occurred flag
    localparam logic [7:0] OFS_SPISTAT = 8'h08; // Early-access error
    localparam logic [7:0] OFS_SETUP = 8'h0C;   // Regulator enable
    localparam logic [7:0] OFS_CFG0 = 8'h10;    // General configuration
    localparam logic [7:0] OFS_WAKE = 8'h14;    // Wake-up command
    // Field positions
    localparam int SRST_UPPER_POS = 7;
    localparam int SRST_LOWER_POS = 0;
    localparam int FLAG_POS = 0;
    localparam int REG_EN_POS = 0;
    // Reset values
    localparam logic [7:0] IFCFG_RST = 8'h00;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [31:0] CFG0_RST = 32'h0000_0000;
    // Clock period and delays in ns, plus delays in cycles
    localparam int CLK_NS = 50;
    localparam int SW_DLY_NS = 1000;
    localparam int SW_DLY_CYC = (SW_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int SRST_CYC = 2;  // Soft reset pulse length
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- edge_sync.sv ----
// Two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps
module edge_sync (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_q; // First stage, read only by the second
    logic sync_q;
    logic last_q;
    // Sync chain plus edge history
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    assign level_o = sync_q;
    assign rise_o = sync_q & ~last_q;
    assign fall_o = ~sync_q & last_q;
endmodule

// ---- ready_timer.sv ----
// Not-ready down counter, reloaded by any reset event
`timescale 1ns/1ps
module ready_timer (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic load_i,
    input wire logic [23:0] count_i,
    output logic busy_o
);
    logic [23:0] cnt_q;
    // Load wins over count down so a late event restarts the window
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= 24'h000000;
        end else if (load_i) begin
            cnt_q <= count_i;
        end else if (cnt_q != 24'h000000) begin
            cnt_q <= cnt_q - 24'h000001;
        end
    end
    assign busy_o = (cnt_q != 24'h000000);
endmodule

// ---- adc_device_reset_control.sv ----
// Device reset controller: reset pin, soft reset, power-on and regulator sequencing
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module adc_device_reset_control #(
    parameter int HW_DLY_CYC = 5000,   // Hardware reset ready delay
    parameter int CORE_DLY_CYC = 6000, // Core supply ready delay
    parameter int IO_DLY_CYC = 6000,   // IO supply ready delay
    parameter int WAKE_DLY_CYC = 8000  // Wake-up command ready delay
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // Device pins from outside the clock domain
    input wire logic RESET_PIN_N_I,
    input wire logic CORE_SUPPLY_I,
    input wire logic IO_SUPPLY_I,
    input wire logic REGULATOR_SUPPLY_INPUT_I,
    input wire logic REGULATOR_FEEDS_CORE_I,
    output logic REGULATOR_OUT_EN_O,
    output logic NOT_READY_O,
    output logic [31:0] CONFIG_O,
    // AXI4-Lite slave
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic pin_level, pin_rise, pin_fall;
    logic core_level, core_rise, core_fall;
    logic io_level, io_rise, io_fall;
    logic rin_level, rin_rise, rin_fall;
    logic feeds_level, feeds_rise, feeds_fall;

    edge_sync u_pin (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(RESET_PIN_N_I),
        .level_o(pin_level), .rise_o(pin_rise), .fall_o(pin_fall));
    edge_sync u_core (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(CORE_SUPPLY_I),
        .level_o(core_level), .rise_o(core_rise), .fall_o(core_fall));
    edge_sync u_io (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(IO_SUPPLY_I),
        .level_o(io_level), .rise_o(io_rise), .fall_o(io_fall));
    edge_sync u_rin (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(REGULATOR_SUPPLY_INPUT_I),
        .level_o(rin_level), .rise_o(rin_rise), .fall_o(rin_fall));
    edge_sync u_feeds (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(REGULATOR_FEEDS_CORE_I),
        .level_o(feeds_level), .rise_o(feeds_rise), .fall_o(feeds_fall));

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] ifcfg_q;       // Interface configuration, soft reset bits
    logic [7:0] setup_q;       // Regulator enable
    logic [31:0] cfg0_q;       // General configuration
    logic flag_q;              // Reset occurred
    logic err_q;               // Early access error
    logic [1:0] srst_cnt_q;    // Soft reset in progress counter
    logic regout_q;            // Regulator output enable, registered
    logic [23:0] load_val_q;   // Selected not-ready count

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake state
    logic aw_hold_q, w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Reset event decode
    wire core_ok = feeds_level ? regout_q : core_level;
    wire hw_evt = pin_fall;
    wire reg_off = feeds_level & ~setup_q[reset_pkg::REG_EN_POS];
    wire core_por = feeds_level ? 1'b0 : core_rise;
    wire io_por = io_rise;
    wire wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
    wire wake_cmd = wr_fire & (awaddr_q == reset_pkg::OFS_WAKE) & wdata_q[0];
    wire reg_por = reg_off & rin_level & io_level & (hw_evt | wake_cmd);
    wire srst_req = wr_fire & (awaddr_q == reset_pkg::OFS_IFCFG) & wstrb_q[0]
        & wdata_q[reset_pkg::SRST_UPPER_POS] & wdata_q[reset_pkg::SRST_LOWER_POS];
    wire srst_done = (srst_cnt_q == 2'd1);
    wire full_rst = hw_evt | core_por | io_por | reg_por;
    wire any_evt = full_rst | srst_req;
    wire not_ready;
    wire valid = ~not_ready;
    wire rd_fire = S_AXI_ARVALID & ~rvalid_q;
    wire [7:0] raddr = S_AXI_ARADDR;

    // Per-source count selection, in one cycle priority runs wake, hardware, IO, core, soft reset
    always_comb begin
        load_val_q = 24'h000000;
        if (srst_req) load_val_q = 24'(reset_pkg::SW_DLY_CYC);
        if (core_por) load_val_q = 24'(CORE_DLY_CYC);
        if (io_por) load_val_q = 24'(IO_DLY_CYC);
        if (hw_evt) load_val_q = 24'(HW_DLY_CYC);
        if (reg_por) load_val_q = 24'(WAKE_DLY_CYC);
    end

    ready_timer u_timer (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .load_i(any_evt),
        .count_i(load_val_q), .busy_o(not_ready));

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers and flags
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ifcfg_q <= reset_pkg::IFCFG_RST;
            setup_q <= reset_pkg::SETUP_RST;
            cfg0_q <= reset_pkg::CFG0_RST;
            srst_cnt_q <= 2'd0;
        end else if (full_rst) begin
            // Full reset; hardware reset also re-enables regulator
            ifcfg_q <= reset_pkg::IFCFG_RST;
            cfg0_q <= reset_pkg::CFG0_RST;
            setup_q <= reset_pkg::SETUP_RST | ((hw_evt | reg_por) ? 8'h01 : 8'h00);
            srst_cnt_q <= 2'd0;
        end else if (srst_req) begin
            // Soft reset takes interface configuration from the written byte
            ifcfg_q <= wdata_q[7:0];
            setup_q <= reset_pkg::SETUP_RST | {7'h00, setup_q[0]};
            cfg0_q <= reset_pkg::CFG0_RST;
            srst_cnt_q <= 2'(reset_pkg::SRST_CYC);
        end else begin
            if (srst_done) begin
                // Soft reset bits self-clear
                ifcfg_q[reset_pkg::SRST_UPPER_POS] <= 1'b0;
                ifcfg_q[reset_pkg::SRST_LOWER_POS] <= 1'b0;
            end
            if (srst_cnt_q != 2'd0) srst_cnt_q <= srst_cnt_q - 2'd1;
            if (wake_cmd) setup_q[0] <= 1'b1;
            // Writes only when ready
            if (wr_fire & valid & wstrb_q[0] & (awaddr_q == reset_pkg::OFS_IFCFG)) ifcfg_q <= wdata_q[7:0];
            if (wr_fire & valid & wstrb_q[0] & (awaddr_q == reset_pkg::OFS_SETUP)) setup_q <= wdata_q[7:0];
            if (wr_fire & valid & (awaddr_q == reset_pkg::OFS_CFG0)) cfg0_q <= wdata_q;
        end
    end

    // Sticky flag and error bit; set beats clear
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            flag_q <= 1'b1;
            err_q <= 1'b0;
        end else begin
            if (any_evt) flag_q <= 1'b1;
            else if (rd_fire & valid & (raddr == reset_pkg::OFS_STATUS)) flag_q <= 1'b0;
            if ((wr_fire | rd_fire) & not_ready) err_q <= 1'b1;
            else if (wr_fire & (awaddr_q == reset_pkg::OFS_SPISTAT) & wdata_q[0]) err_q <= 1'b0;
        end
    end

    // Regulator output gated by supplies and enable bit
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) regout_q <= 1'b0;
        else regout_q <= rin_level & io_level & setup_q[reset_pkg::REG_EN_POS];
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data latched in either order
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= reset_pkg::RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID & S_AXI_AWREADY) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID & S_AXI_WREADY) begin
                w_hold_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                // Early access answered with slave error
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= not_ready ? reset_pkg::RESP_SLVERR : reset_pkg::RESP_OKAY;
            end else if (bvalid_q & S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign S_AXI_AWREADY = ~aw_hold_q & ~bvalid_q;
    assign S_AXI_WREADY = ~w_hold_q & ~bvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path; unmapped reads return zero with slave error
    wire hit_if = (raddr == reset_pkg::OFS_IFCFG);
    wire hit_st = (raddr == reset_pkg::OFS_STATUS);
    wire hit_sp = (raddr == reset_pkg::OFS_SPISTAT);
    wire hit_su = (raddr == reset_pkg::OFS_SETUP);
    wire hit_c0 = (raddr == reset_pkg::OFS_CFG0);
    wire hit_wk = (raddr == reset_pkg::OFS_WAKE);
    wire mapped = hit_if | hit_st | hit_sp | hit_su | hit_c0 | hit_wk;
    wire [31:0] rmux = hit_if ? {24'h000000, ifcfg_q} :
                       hit_st ? {31'h0, flag_q} :
                       hit_sp ? {31'h0, err_q} :
                       hit_su ? {24'h000000, setup_q} :
                       hit_c0 ? cfg0_q : 32'h0000_0000;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= reset_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= not_ready ? 32'h0000_0000 : rmux;
            rresp_q <= (not_ready | ~mapped) ? reset_pkg::RESP_SLVERR : reset_pkg::RESP_OKAY;
        end else if (rvalid_q & S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    assign S_AXI_ARREADY = ~rvalid_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    assign REGULATOR_OUT_EN_O = regout_q;
    assign NOT_READY_O = not_ready;
    assign CONFIG_O = cfg0_q;
endmodule

// ---- reset_ctrl_sva.sv ----
// Port-level checks for the reset controller
`timescale 1ns/1ps
module reset_ctrl_sva (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic RESET_PIN_N_I,
    input wire logic IO_SUPPLY_I,
    input wire logic REGULATOR_SUPPLY_INPUT_I,
    input wire logic REGULATOR_OUT_EN_O,
    input wire logic NOT_READY_O,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_BVALID,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP
);
    // One clock domain; reset aborts every check
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    ////////////////////////////////////////
    // Accesses inside the not-ready window get an error answer
    refuse_wr_a: assert property (
        $rose(S_AXI_BVALID) && $past(NOT_READY_O) |-> S_AXI_BRESP == reset_pkg::RESP_SLVERR)
        else $error("write in not-ready window not refused");
    refuse_rd_a: assert property (
        $rose(S_AXI_RVALID) && $past(NOT_READY_O) |-> S_AXI_RRESP == reset_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("read in not-ready window not refused");
    aw_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
        else $error("write address taken while response pending");
    ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address taken while data pending");
    ////////////////////////////////////////
    // Reset sources open the window within the synchroniser delay
    pin_fall_a: assert property ($fell(RESET_PIN_N_I) |-> ##[1:6] NOT_READY_O)
        else $error("reset pin fall did not start a reset");
    io_por_a: assert property ($rose(IO_SUPPLY_I) |-> ##[1:6] NOT_READY_O)
        else $error("io supply arrival did not start a reset");
    window_a: assert property ($rose(NOT_READY_O) |-> NOT_READY_O [*8])
        else $error("not-ready window too short");
    reg_off_a: assert property (!(IO_SUPPLY_I && REGULATOR_SUPPLY_INPUT_I) [*6] |-> !REGULATOR_OUT_EN_O)
        else $error("regulator on without its supplies");
    // Main scenarios reached
    cover property ($rose(NOT_READY_O));
    cover property (S_AXI_BVALID && S_AXI_BRESP == reset_pkg::RESP_SLVERR);
    cover property ($fell(REGULATOR_OUT_EN_O));
endmodule
bind adc_device_reset_control reset_ctrl_sva i_reset_ctrl_sva (.*);

// ---- host_pins.sv ----
// Far-side model: the host's reset pin and supply control
`timescale 1ns/1ps
module host_pins (
    input wire logic CLK_I,
    output logic RESET_PIN_N_I,
    output logic CORE_SUPPLY_I,
    output logic IO_SUPPLY_I,
    output logic REGULATOR_SUPPLY_INPUT_I,
    output logic REGULATOR_FEEDS_CORE_I
);
    // Supplies present, pin released, core on its own supply
    initial begin
        {RESET_PIN_N_I, CORE_SUPPLY_I, IO_SUPPLY_I, REGULATOR_SUPPLY_INPUT_I} = 4'hF;
        REGULATOR_FEEDS_CORE_I = 1'b0;
    end
    ////////////////////////////////////////
    // Pin pulse; caller picks a low time above the minimum
    task automatic pulse(input int n);
        @(posedge CLK_I);
        RESET_PIN_N_I <= 1'b0;
        repeat (n) @(posedge CLK_I);
        RESET_PIN_N_I <= 1'b1;
    endtask
    // Supply change, then time for the synchronisers to pass it
    task automatic supply(input logic c, input logic i, input logic f);
        @(posedge CLK_I);
        {CORE_SUPPLY_I, IO_SUPPLY_I, REGULATOR_FEEDS_CORE_I} <= {c, i, f};
        repeat (6) @(posedge CLK_I);
        @(negedge CLK_I);
    endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the reset controller
`timescale 1ns/1ps
module tb;
    logic CLK_I, RESET_N_I, RESET_PIN_N_I, CORE_SUPPLY_I, IO_SUPPLY_I, NOT_READY_O;
    logic REGULATOR_SUPPLY_INPUT_I, REGULATOR_FEEDS_CORE_I, REGULATOR_OUT_EN_O;
    logic [31:0] CONFIG_O, S_AXI_WDATA, S_AXI_RDATA;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
    logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    int err_count = 0;
    int tests_run = 0;
    localparam logic [1:0] OK = reset_pkg::RESP_OKAY;
    localparam logic [1:0] SE = reset_pkg::RESP_SLVERR;
    localparam logic [7:0] STA = reset_pkg::OFS_STATUS;
    // Short delays keep the run brief
    adc_device_reset_control #(.HW_DLY_CYC(20), .CORE_DLY_CYC(20), .IO_DLY_CYC(20), .WAKE_DLY_CYC(20))
        i_adc_device_reset_control (.*);
    host_pins i_host_pins (.*);
    // 20 MHz clock
    initial begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, exp, got);
        end
    endtask
    // One transfer; ready sampled at the negedge equals its value at the next edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic done;
        logic [2:0] tk;
        logic [31:0] rd;
        logic [1:0] rs;
        done = 1'b0;
        @(posedge CLK_I);
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} <= {a, a, d};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} <= {{3{wr}}, {2{!wr}}};
        while (!done) begin
            @(negedge CLK_I);
            tk = {S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY};
            done = wr ? S_AXI_BVALID : S_AXI_RVALID;
            rs = wr ? S_AXI_BRESP : S_AXI_RRESP;
            rd = S_AXI_RDATA;
            @(posedge CLK_I);
            {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} <= {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} & ~tk;
            {S_AXI_BREADY, S_AXI_RREADY} <= {S_AXI_BREADY, S_AXI_RREADY} & {2{!done}};
        end
        // Released payload no longer shows the old value
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} <= ~{a, a, d};
        chk("resp", {30'h0, rs}, {30'h0, e});
        if (!wr) chk("rdata", rd, d);
    endtask
    // Wait out a not-ready window, bounded by the watchdog
    task automatic settle();
        repeat (6) @(posedge CLK_I);
        while (NOT_READY_O !== 1'b0) @(posedge CLK_I);
        @(negedge CLK_I);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog well above the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge CLK_I);
        err_count++;
        wrap_up();
    end
    ////////////////////////////////////////
    initial begin
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
        S_AXI_WSTRB = 4'hF;
        RESET_N_I = 1'b0;
        repeat (5) @(posedge CLK_I);
        RESET_N_I <= 1'b1;
        // Supplies already present look like a fresh arrival after release
        settle();
        xfer(1'b0, STA, 32'h1, OK);
        xfer(1'b0, STA, 32'h0, OK);
        xfer(1'b0, 8'h20, 32'h0, SE);
        // Soft reset, then early accesses refused
        xfer(1'b1, reset_pkg::OFS_CFG0, 32'hA5A5_5A5A, OK);
        xfer(1'b1, reset_pkg::OFS_IFCFG, 32'hA5, OK);
        xfer(1'b1, reset_pkg::OFS_CFG0, 32'h1234_5678, SE);
        settle();
        chk("config", CONFIG_O, reset_pkg::CFG0_RST);
        xfer(1'b0, reset_pkg::OFS_IFCFG, 32'h24, OK);
        xfer(1'b1, reset_pkg::OFS_SPISTAT, 32'h0, OK);
        xfer(1'b0, reset_pkg::OFS_SPISTAT, 32'h1, OK);
        xfer(1'b1, reset_pkg::OFS_SPISTAT, 32'h1, OK);
        xfer(1'b0, reset_pkg::OFS_SPISTAT, 32'h0, OK);
        // Hardware reset with the regulator disabled
        xfer(1'b1, reset_pkg::OFS_CFG0, 32'hC3, OK);
        xfer(1'b1, reset_pkg::OFS_SETUP, 32'h0, OK);
        i_host_pins.pulse(4);
        @(negedge CLK_I);
        chk("busy", {31'h0, NOT_READY_O}, 32'h1);
        settle();
        chk("config", CONFIG_O, reset_pkg::CFG0_RST);
        xfer(1'b0, reset_pkg::OFS_SETUP, 32'h1, OK);
        xfer(1'b0, STA, 32'h1, OK);
        // IO supply lost, then its return resets the device
        i_host_pins.supply(1'b1, 1'b0, 1'b0);
        chk("reg_out", {31'h0, REGULATOR_OUT_EN_O}, 32'h0);
        i_host_pins.supply(1'b1, 1'b1, 1'b0);
        settle();
        xfer(1'b0, reset_pkg::OFS_SETUP, 32'h0, OK);
        // Wake-up command while the regulator feeds the core
        i_host_pins.supply(1'b1, 1'b1, 1'b1);
        xfer(1'b0, STA, 32'h1, OK);
        xfer(1'b1, reset_pkg::OFS_WAKE, 32'h1, OK);
        settle();
        chk("reg_out", {31'h0, REGULATOR_OUT_EN_O}, 32'h1);
        xfer(1'b0, STA, 32'h1, OK);
        wrap_up();
    end
endmodule
